// File: eair_resolver.v
// egress action index resolver: protection, pop count, stat index, mapping indices
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`include "eair_defines.vh"

module eair_resolver #(
  parameter SVC_W = 12,
  parameter MEP_W = 12,
  parameter MAP_N = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  // avalon-mm register slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // action from the egress lookup stage

  // action from the lookup stage, all fields qualified by act_valid_i
  input wire act_valid_i,
  input wire [1:0] prot_sel_i,
  input wire [6:0] encap_table_index_i,
  input wire [6:0] encap_table_index_protected_i,
  input wire [SVC_W-1:0] service_counter_base_i,
  input wire [SVC_W-1:0] service_counter_base_protected_i,
  input wire [MEP_W-1:0] maint_endpoint_index_i,
  input wire [MEP_W-1:0] maint_endpoint_index_protected_i,

  // pop override and per-class counter offsets
  input wire [4:0] pop_count_i,
  input wire [23:0] per_class_counter_offsets_i,

  // mapping lanes: 8-bit base and 4-bit key per lane
  input wire [8*MAP_N-1:0] map_base_i,
  input wire [4*MAP_N-1:0] map_key_i,
  // internal frame header fields
  input wire prot_active_i,

  // header pop count in 16-bit words
  input wire [4:0] header_word_pop_count_i,

  // classification fields feeding the mapping keys
  input wire [2:0] class_of_service_id_i,
  input wire [2:0] qos_class_i,
  input wire [1:0] drop_prec_i,
  input wire [5:0] dscp_i,
  input wire [2:0] tos_prec_i,
  input wire [2:0] pcp_i,
  input wire dei_i,
  input wire [2:0] traffic_class_i,
  input wire [2:0] popped_pcp_i,
  input wire popped_dei_i,

  // resolved results, one cycle after the action
  output reg res_valid_o,
  output reg encap_push_o,
  output reg [6:0] encap_table_index_o,
  output reg [SVC_W-1:0] service_counter_base_o,
  output reg [SVC_W-1:0] stat_index_o,
  output reg [MEP_W-1:0] maint_endpoint_index_o,
  output reg [5:0] pop_bytes_o,
  output reg [11*MAP_N-1:0] map_index_o
);


  // software control bits and statistics
  reg [1:0] ctrl;
  reg [31:0] frame_count;
  reg [31:0] rsvd_count;


  // offset within a mapping table, chosen by the key
  function [7:0] key_offset;
    input [3:0] key;
    input [2:0] qos;
    input [1:0] dp;
    input [5:0] dscp;
    input [2:0] tos;
    input [2:0] pcp;
    input dei;
    input [2:0] tc;
    input [2:0] ppcp;
    input pdei;
    input [2:0] class_of_service_id;
    begin
      case (key)
        `EAIR_KEY_QOS: key_offset = {5'h00, qos};
        `EAIR_KEY_DP_QOS: key_offset = {3'h0, dp, qos};
        `EAIR_KEY_DSCP: key_offset = {2'h0, dscp};
        `EAIR_KEY_DP_DSCP: key_offset = {dp, dscp};
        `EAIR_KEY_DP_TOS: key_offset = {3'h0, dp, tos};
        `EAIR_KEY_PCP: key_offset = {5'h00, pcp};
        `EAIR_KEY_DP_PCP: key_offset = {3'h0, dp, pcp};
        `EAIR_KEY_DEI_PCP: key_offset = {4'h0, dei, pcp};
        `EAIR_KEY_TC: key_offset = {5'h00, tc};
        `EAIR_KEY_DP_TC: key_offset = {3'h0, dp, tc};
        `EAIR_KEY_POP_PCP: key_offset = {5'h00, ppcp};
        `EAIR_KEY_DP_POP_PCP: key_offset = {3'h0, dp, ppcp};
        `EAIR_KEY_POP_DEI_PCP: key_offset = {4'h0, pdei, ppcp};
        `EAIR_KEY_CLASS_OF_SERVICE_ID: key_offset = {5'h00, class_of_service_id};
        // undefined keys fall back to the table base
        default: key_offset = 8'h00;
      endcase
    end
  endfunction

  // protection decision; reserved selector means working indices
  reg use_prot;
  always @* begin
    case (prot_sel_i)
      `EAIR_PROT_IF_ACTIVE: use_prot = prot_active_i;
      `EAIR_PROT_IF_IDLE: use_prot = ~prot_active_i;
      default: use_prot = 1'b0;
    endcase
    if (!ctrl[`EAIR_CTRL_PROT_EN]) begin
      use_prot = 1'b0;
    end
  end

  // one decision drives all three indices so they never disagree
  wire [6:0] next_encap = use_prot ? encap_table_index_protected_i : encap_table_index_i;
  wire [SVC_W-1:0] next_svc = use_prot ? service_counter_base_protected_i : service_counter_base_i;
  wire [MEP_W-1:0] next_mep = use_prot ? maint_endpoint_index_protected_i : maint_endpoint_index_i;

  // per-class counter offset slice
  wire [2:0] cos_offset = per_class_counter_offsets_i[class_of_service_id_i*`EAIR_COS_FIELD_W +: `EAIR_COS_FIELD_W];
  wire [SVC_W-1:0] next_stat = next_svc + {{(SVC_W-3){1'b0}}, cos_offset};

  // pop byte count: header words vs action override
  wire [5:0] hdr_bytes = {header_word_pop_count_i, 1'b0};
  wire pop_rsvd = pop_count_i > `EAIR_POP_MAX;
  reg [5:0] next_pop;
  always @* begin
    next_pop = hdr_bytes;
    if (ctrl[`EAIR_CTRL_POP_EN] && pop_count_i != `EAIR_POP_USE_HDR && !pop_rsvd) begin
      if (pop_count_i == `EAIR_POP_NONE) begin
        next_pop = 6'h00;
      end else if ({pop_count_i, 1'b0} <= hdr_bytes) begin
        next_pop = {pop_count_i, 1'b0};
      end
      // larger than the header count: header wins, already set above
      // so a bad action can never pop bytes the header did not announce
      next_pop = next_pop;
    end
  end

  // mapping indices: lanes 0,1 form resource A, lanes 2,3 resource B
  wire [11*MAP_N-1:0] next_map;
  genvar g;
  generate
    for (g = 0; g < MAP_N; g = g + 1) begin : g_map
      wire [7:0] off = key_offset(map_key_i[4*g +: 4], qos_class_i, drop_prec_i, dscp_i, tos_prec_i,
                                  pcp_i, dei_i, traffic_class_i, popped_pcp_i, popped_dei_i,
                                  class_of_service_id_i);
      // base fills bits 10:3; wide keys carry into the base bits
      assign next_map[11*g +: 11] = {map_base_i[8*g +: 8], 3'h0} + {3'h0, off};
    end
  endgenerate

  // result stage, registered so every output comes from a flop
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res_valid_o <= 1'b0;
      encap_push_o <= 1'b0;
      encap_table_index_o <= 7'h00;
      service_counter_base_o <= {SVC_W{1'b0}};
      stat_index_o <= {SVC_W{1'b0}};
      maint_endpoint_index_o <= {MEP_W{1'b0}};
      pop_bytes_o <= 6'h00;
      map_index_o <= {(11*MAP_N){1'b0}};
    end else begin
      res_valid_o <= act_valid_i;
      if (act_valid_i) begin
        encap_push_o <= next_encap != 7'h00;
        encap_table_index_o <= next_encap;
        service_counter_base_o <= next_svc;
        stat_index_o <= next_stat;
        maint_endpoint_index_o <= next_mep;
        pop_bytes_o <= next_pop;
        map_index_o <= next_map;
      end
    end
  end

  // statistics for software: frames resolved and frames with reserved codes
  wire rsvd_seen = pop_rsvd | (prot_sel_i == `EAIR_PROT_RSVD);
  reg [31:0] next_frame_count;
  reg [31:0] next_rsvd_count;

  // frame counter advances once per action, reserved counter only on a reserved code; a reserved code is counted, not refused
  always @* begin
    next_frame_count = frame_count;
    next_rsvd_count = rsvd_count;
    if (act_valid_i) begin
      next_frame_count = frame_count + 32'h00000001;
      if (rsvd_seen) begin
        next_rsvd_count = rsvd_count + 32'h00000001;
      end
    end
  end

  // counters wrap silently; software works with differences of two reads
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      frame_count <= 32'h00000000;
      rsvd_count <= 32'h00000000;
    end else begin
      frame_count <= next_frame_count;
      rsvd_count <= next_rsvd_count;
    end
  end

  // avalon slave: one wait cycle, then answer; write lands on the answering edge
  wire req = avs_read_i | avs_write_i;
  // request seen while idle: start the single wait cycle
  wire take = req & avs_waitrequest_o;
  // write commits only where the master samples waitrequest low
  wire commit = avs_write_i & ~avs_waitrequest_o;
  // control register hit; byte lane 0 carries both bits
  wire ctrl_hit = (avs_address_i == `EAIR_ADDR_CTRL) & avs_byteenable_i[0];
  reg [31:0] next_rdata;
  reg next_wait;
  reg [31:0] next_readdata;
  reg [1:0] next_ctrl;

  // read mux; unmapped addresses answer zero
  always @* begin
    case (avs_address_i)
      `EAIR_ADDR_CTRL: next_rdata = {30'h00000000, ctrl};
      `EAIR_ADDR_FRAMES: next_rdata = frame_count;
      `EAIR_ADDR_RSVD_SEEN: next_rdata = rsvd_count;
      default: next_rdata = 32'h00000000;
    endcase
  end


  // next bus state; waitrequest drops for exactly one cycle per request
  always @* begin
    next_wait = ~take;
    next_readdata = avs_readdata_o;
    next_ctrl = ctrl;
    if (take) begin
      // read data loaded early so it stands at the answering edge
      next_readdata = avs_read_i ? next_rdata : 32'h00000000;
    end
    if (commit && ctrl_hit) begin
      next_ctrl = avs_writedata_i[1:0];
    end
  end

  // bus registers; back to back requests each pay one wait cycle
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      ctrl <= `EAIR_CTRL_RESET;
    end else begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_readdata;
      ctrl <= next_ctrl;
    end
  end

endmodule

// File: eair_defines.vh
// constants for the egress action index resolver
`ifndef EAIR_DEFINES_VH
`define EAIR_DEFINES_VH
// protection selector codes
`define EAIR_PROT_NONE 2'h0
`define EAIR_PROT_IF_ACTIVE 2'h1
`define EAIR_PROT_IF_IDLE 2'h2
`define EAIR_PROT_RSVD 2'h3
// pop count encodings
`define EAIR_POP_USE_HDR 5'h00
`define EAIR_POP_NONE 5'h01
`define EAIR_POP_MAX 5'h15
// mapping key codes
`define EAIR_KEY_QOS 4'h0
`define EAIR_KEY_DP_QOS 4'h1
`define EAIR_KEY_DSCP 4'h2
`define EAIR_KEY_DP_DSCP 4'h3
`define EAIR_KEY_DP_TOS 4'h4
`define EAIR_KEY_PCP 4'h5
`define EAIR_KEY_DP_PCP 4'h6
`define EAIR_KEY_DEI_PCP 4'h7
`define EAIR_KEY_TC 4'h8
`define EAIR_KEY_DP_TC 4'h9
`define EAIR_KEY_POP_PCP 4'hA
`define EAIR_KEY_DP_POP_PCP 4'hB
`define EAIR_KEY_POP_DEI_PCP 4'hC
`define EAIR_KEY_CLASS_OF_SERVICE_ID 4'hD
// field geometry
`define EAIR_MAP_LOW_BITS 3
`define EAIR_COS_FIELD_W 3
// register byte addresses
`define EAIR_ADDR_CTRL 4'h0
`define EAIR_ADDR_FRAMES 4'h4
`define EAIR_ADDR_RSVD_SEEN 4'h8
// control bits and reset value
`define EAIR_CTRL_PROT_EN 0
`define EAIR_CTRL_POP_EN 1
`define EAIR_CTRL_RESET 2'h3
`endif

// File: eair_lookup_model.sv
// stand-in for the egress lookup engine that launches actions
`timescale 1ns/1ns
module eair_lookup_model (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire fire_i,
  output reg act_valid_o
);
  // one registered pulse per request, silent while in reset
  always @(posedge core_clk_i) begin
    act_valid_o <= rst_n_i & fire_i;
  end
endmodule

// File: eair_props.sv
// assertions on the resolver action path
`timescale 1ns/1ns
`include "eair_defines.vh"
module eair_props #(
  parameter SVC_W = 12,
  parameter MEP_W = 12,
  parameter MAP_N = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire act_valid_i,
  input wire [1:0] prot_sel_i,
  input wire prot_active_i,
  input wire [6:0] encap_table_index_i,
  input wire [6:0] encap_table_index_protected_i,
  input wire [SVC_W-1:0] service_counter_base_i,
  input wire [SVC_W-1:0] service_counter_base_protected_i,
  input wire [MEP_W-1:0] maint_endpoint_index_i,
  input wire [MEP_W-1:0] maint_endpoint_index_protected_i,
  input wire [4:0] pop_count_i,
  input wire [4:0] header_word_pop_count_i,
  input wire [23:0] per_class_counter_offsets_i,
  input wire [2:0] class_of_service_id_i,
  input wire [8*MAP_N-1:0] map_base_i,
  input wire [4*MAP_N-1:0] map_key_i,
  input wire [2:0] qos_class_i,
  input wire encap_push_o,
  input wire [6:0] encap_table_index_o,
  input wire [SVC_W-1:0] service_counter_base_o,
  input wire [SVC_W-1:0] stat_index_o,
  input wire [MEP_W-1:0] maint_endpoint_index_o,
  input wire [5:0] pop_bytes_o,
  input wire [11*MAP_N-1:0] map_index_o
);
  // expectations formed at the action; control register assumed left at reset
  wire use_p = (prot_sel_i == 2'h1 && prot_active_i) || (prot_sel_i == 2'h2 && !prot_active_i);
  wire [2:0] cos_off = per_class_counter_offsets_i >> (3 * class_of_service_id_i);
  wire [4:0] pop_min = (pop_count_i > header_word_pop_count_i) ? header_word_pop_count_i : pop_count_i;
  wire [7:0] base0 = map_base_i[7:0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  push_flag_a: assert property (encap_push_o == (encap_table_index_o != 7'h00))
    else $error("push flag wrong");
  prot_swap_a: assert property (act_valid_i && use_p |=>
    encap_table_index_o == $past(encap_table_index_protected_i) &&
    service_counter_base_o == $past(service_counter_base_protected_i) &&
    maint_endpoint_index_o == $past(maint_endpoint_index_protected_i)) else $error("protected set not used");
  no_prot_a: assert property (act_valid_i && !use_p |=>
    encap_table_index_o == $past(encap_table_index_i) &&
    maint_endpoint_index_o == $past(maint_endpoint_index_i)) else $error("working set not used");
  stat_sum_a: assert property (act_valid_i |=>
    stat_index_o == service_counter_base_o + $past(cos_off)) else $error("stat index wrong");
  pop_hdr_a: assert property (act_valid_i && (pop_count_i == 5'h00 || pop_count_i > 5'h15) |=>
    pop_bytes_o == {$past(header_word_pop_count_i), 1'b0}) else $error("header pop not used");
  pop_one_a: assert property (act_valid_i && pop_count_i == 5'h01 |=> pop_bytes_o == 6'h00)
    else $error("pop one not zero");
  pop_cap_a: assert property (act_valid_i && pop_count_i > 5'h01 && pop_count_i < 5'h16 |=>
    pop_bytes_o == {$past(pop_min), 1'b0}) else $error("pop bytes wrong");
  map_qos_a: assert property (act_valid_i && map_key_i[3:0] == `EAIR_KEY_QOS |=>
    map_index_o[10:0] == {$past(base0), $past(qos_class_i)}) else $error("map index wrong");
  cover property (act_valid_i && use_p);
  cover property (act_valid_i && pop_count_i > header_word_pop_count_i);
  cover property (act_valid_i && prot_sel_i == 2'h3);
endmodule
bind eair_resolver eair_props #(.SVC_W(SVC_W), .MEP_W(MEP_W), .MAP_N(MAP_N)) i_eair_props (.*);

// File: eair_resolver_tb_top.sv
// self-checking bench for the egress action index resolver
`timescale 1ns/1ns
module eair_resolver_tb_top;
  logic core_clk_i, rst_n_i, avs_read_i, avs_write_i, fire, act_valid_i, prot_active_i, dei_i, popped_dei_i;
  logic avs_waitrequest_o, res_valid_o, encap_push_o, p;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd, map_base_i;
  logic [1:0] prot_sel_i, drop_prec_i;
  logic [6:0] encap_table_index_i, encap_table_index_protected_i, encap_table_index_o;
  logic [11:0] service_counter_base_i, service_counter_base_protected_i, maint_endpoint_index_i;
  logic [11:0] maint_endpoint_index_protected_i, service_counter_base_o, stat_index_o, maint_endpoint_index_o;
  logic [4:0] pop_count_i, header_word_pop_count_i;
  logic [23:0] per_class_counter_offsets_i;
  logic [15:0] map_key_i;
  logic [2:0] class_of_service_id_i, qos_class_i, tos_prec_i, pcp_i, traffic_class_i, popped_pcp_i;
  logic [5:0] dscp_i, pop_bytes_o, pb;
  logic [43:0] map_index_o;
  int error_cnt, comparisons, cyc;
  // low-part offsets per key for the fixed header fields below
  byte unsigned offs [16] = '{3, 19, 21, 149, 22, 5, 21, 13, 7, 23, 2, 18, 10, 5, 0, 0};
  localparam logic [39:0] pop_list = 40'hFDAAB50820;

  eair_lookup_model i_eair_lookup_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .act_valid_o(act_valid_i));
  eair_resolver i_eair_resolver (.*);

  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // one avalon transfer; an idle cycle follows so requests never merge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // sweep selector, flag, pop code, class and key from one index
  task act(input logic [3:0] i);
    prot_sel_i <= i[1:0];
    prot_active_i <= i[2];
    pop_count_i <= pop_list[5*i[2:0] +: 5];
    class_of_service_id_i <= i[2:0];
    encap_table_index_protected_i <= i[3] ? 7'h7F : 7'h00;
    map_key_i <= {4{i}};
    fire <= 1'b1;
    @(posedge core_clk_i);
    fire <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask

  task end_sim;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // hang guard, far above the roughly 56 cycles the sequence needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim;
    end
  end

  initial begin
    {rst_n_i, avs_read_i, avs_write_i, fire, prot_active_i, prot_sel_i, pop_count_i, map_key_i} = '0;
    {avs_address_i, avs_writedata_i, encap_table_index_protected_i, class_of_service_id_i} = '0;
    {dei_i, popped_dei_i, drop_prec_i, qos_class_i, dscp_i, tos_prec_i, pcp_i, traffic_class_i, popped_pcp_i} =
      {1'b1, 1'b1, 2'h2, 3'h3, 6'h15, 3'h6, 3'h5, 3'h7, 3'h2};
    {encap_table_index_i, service_counter_base_i, service_counter_base_protected_i} = {7'h05, 12'h100, 12'h200};
    {maint_endpoint_index_i, maint_endpoint_index_protected_i} = {12'h011, 12'h022};
    {header_word_pop_count_i, per_class_counter_offsets_i, map_base_i} = {5'h0A, 24'hFAC688, 32'h40302010};
    avs_byteenable_i = 4'h0;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    bus(1'b1, 4'h0, 32'h0, rd);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, 4'h0, 32'h0, rd);
    chk(rd, 32'h3);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      act(i[3:0]);
      p = (i[1:0] == 2'h1 && i[2]) || (i[1:0] == 2'h2 && !i[2]);
      pb = (pop_count_i == 5'h01) ? 6'h00 : (pop_count_i == 5'h00 || pop_count_i > 5'h0A) ? 6'h14 : {pop_count_i, 1'b0};
      chk(encap_table_index_o, p ? encap_table_index_protected_i : 7'h05);
      chk(res_valid_o, 1'b1);
      chk(encap_push_o, p ? i[3] : 1'b1);
      chk(service_counter_base_o, p ? 12'h200 : 12'h100);
      chk(maint_endpoint_index_o, p ? 12'h022 : 12'h011);
      chk(stat_index_o, (p ? 12'h200 : 12'h100) + i[2:0]);
      chk(pop_bytes_o, pb);
      for (int g = 0; g < 4; g++) chk(map_index_o[11*g +: 11], (g + 1) * 128 + offs[i]);
    end
    bus(1'b0, 4'h4, 32'h0, rd);
    chk(rd, 32'h10);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk(rd, 32'h6);
    end_sim;
  end
endmodule
